// File: bench/testbench.sv
// Self-checking bench for the interrupt controller.
// Assumes the sequencer model drives instruction boundaries.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic MCLK = 1'b0;
	logic RST = 1'b1;
	tlic_pkg::tlic_sfr_req_type req = '0;
	logic [22:0] hw_set = '0;
	logic [22:0] sw_set = '0;
	logic [22:0] sw_clr = '0;
	logic [2:0] gap = 3'h1;
	logic return_from_interrupt_req = 1'b0;
	logic [7:0] rdata;
	logic [22:0] pend;
	logic iend;
	logic rend;
	logic irq;
	tlic_pkg::tlic_call_type call;
	tlic_pkg::tlic_svc_type svc;
	int err_count = 0;
	int n_tests = 0;
	int lat;
	int src_flag [15] = '{0, 1, 2, 3, 5, 7, 11, 12, 13, 17, 18, 19, 20, 21, 22};
	tlic_top i_dut (.MCLK(MCLK), .RST(RST), .SFR_REQ(req), .SFR_RDATA(rdata),
		.FLAG_HW_SET(hw_set), .FLAG_SW_SET(sw_set), .FLAG_SW_CLR(sw_clr),
		.PENDING_FLAGS(pend), .INSTR_END(iend), .RETURN_FROM_INTERRUPT_END(rend),
		.IRQ_PENDING(irq), .LONG_CALL(call), .SERVICE_STATE(svc));
	tlic_cpu_model i_cpu (.clk(MCLK), .rst(RST), .gap(gap),
		.return_from_interrupt_req(return_from_interrupt_req), .instr_end(iend), .return_from_interrupt_end(rend));
	initial
	begin
		forever #10 MCLK = ~MCLK;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("tests %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		n_tests++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge MCLK);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req = '{1'b1, a, d};
		tick(1);
		req.wr = 1'b0;
		// Idle edge so a following request never reassigns in this step
		tick(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		req.addr = a;
		tick(1);
		chk("sfr_rdata", {8'h00, exp}, {8'h00, rdata});
	endtask
	task automatic flag(input int i, input logic clr);
		if (clr)
			sw_clr[i] = 1'b1;
		else
			sw_set[i] = 1'b1;
		tick(1);
		sw_set = '0;
		sw_clr = '0;
	endtask
	task automatic wait_go(input logic [15:0] vec, input logic hi);
		lat = 0;
		while (call.go !== 1'b1 && lat < 40)
		begin
			tick(1);
			lat++;
		end
		if (call.go !== 1'b1)
		begin
			err_count++;
			results();
		end
		chk("call_vector", vec, call.vector);
		chk("call_high", {15'h0, hi}, {15'h0, call.high});
		tick(1);
	endtask
	task automatic no_go(input int n);
		repeat (n)
		begin
			tick(1);
			chk("no_call", 16'h0, {15'h0, call.go});
			chk("irq_pending", 16'h0, {15'h0, irq});
		end
	endtask
	// Returns just after the state copy has caught up
	task automatic ret();
		int i;
		return_from_interrupt_req = 1'b1;
		tick(1);
		return_from_interrupt_req = 1'b0;
		i = 0;
		while (rend !== 1'b1 && i < 20)
		begin
			tick(1);
			i++;
		end
		if (rend !== 1'b1)
		begin
			err_count++;
			results();
		end
		tick(2);
	endtask
	task automatic svc_is(input tlic_pkg::tlic_svc_type s);
		chk("svc_state", {14'h0, s}, {14'h0, svc});
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		tick(6);
		RST = 1'b0;
		chk("reset_vector", 16'h0000, call.vector);
		svc_is(tlic_pkg::SVC_IDLE);
		rd(8'hA8, 8'h00);
		rd(8'hB8, 8'h80);
		rd(8'hE6, 8'h00);
		rd(8'hF6, 8'h00);
		wr(8'hB8, 8'h7F);
		rd(8'hB8, 8'hFF);
		wr(8'hB8, 8'h00);
		wr(8'h99, 8'h55);
		rd(8'h99, 8'h00);
		$display("registers done");
		hw_set[13] = 1'b1;
		tick(1);
		hw_set = '0;
		chk("pending", 16'h1, {15'h0, pend[13]});
		wr(8'hA8, 8'h80);
		no_go(10);
		wr(8'hA8, 8'h00);
		wr(8'hE6, 8'h02);
		no_go(10);
		wr(8'hA8, 8'h80);
		wait_go(16'h0043, 1'b0);
		chk("pending", 16'h1, {15'h0, pend[13]});
		flag(13, 1'b1);
		ret();
		svc_is(tlic_pkg::SVC_IDLE);
		$display("masking done");
		wr(8'hA8, 8'hFF);
		wr(8'hE6, 8'hFF);
		rd(8'hE6, 8'hFF);
		for (int s = 0; s < 15; s++)
		begin
			flag(src_flag[s], 1'b0);
			wait_go(16'h0003 + 16'(8 * s), 1'b0);
			chk("auto_clear", {15'h0, s > 3}, {15'h0, pend[src_flag[s]]});
			flag(src_flag[s], 1'b1);
			ret();
		end
		$display("sources done");
		wr(8'hF6, 8'h02);
		rd(8'hF6, 8'h02);
		sw_set = 23'h0020A1;
		tick(1);
		sw_set = '0;
		wait_go(16'h0043, 1'b1);
		no_go(8);
		flag(13, 1'b1);
		ret();
		wait_go(16'h0003, 1'b0);
		flag(13, 1'b0);
		wait_go(16'h0043, 1'b1);
		svc_is(tlic_pkg::SVC_HIGH_OVER_LOW);
		flag(13, 1'b1);
		ret();
		svc_is(tlic_pkg::SVC_LOW);
		no_go(6);
		ret();
		wait_go(16'h0023, 1'b0);
		ret();
		wait_go(16'h0023, 1'b0);
		flag(5, 1'b1);
		ret();
		wait_go(16'h002B, 1'b0);
		flag(7, 1'b1);
		ret();
		svc_is(tlic_pkg::SVC_IDLE);
		$display("priority done");
		gap = 3'h0;
		flag(1, 1'b0);
		wait_go(16'h000B, 1'b0);
		chk("latency", 16'h1, {15'h0, lat <= 2});
		ret();
		$display("latency done");
		results();
	end
endmodule
`default_nettype wire

// File: bench/tlic_checker.sv
// Port checker for the interrupt controller top.
// Assumes one clock domain and a synchronous reset.
`default_nettype none
module tlic_checker #(
	parameter int NUM_FLAG = tlic_pkg::NUM_FLAG
) (
	input wire logic MCLK,
	input wire logic RST,
	input wire tlic_pkg::tlic_sfr_req_type SFR_REQ,
	input wire logic [7:0] SFR_RDATA,
	input wire logic [NUM_FLAG-1:0] FLAG_HW_SET,
	input wire logic [NUM_FLAG-1:0] FLAG_SW_SET,
	input wire logic [NUM_FLAG-1:0] PENDING_FLAGS,
	input wire logic INSTR_END,
	input wire logic RETURN_FROM_INTERRUPT_END,
	input wire logic IRQ_PENDING,
	input wire tlic_pkg::tlic_call_type LONG_CALL,
	input wire tlic_pkg::tlic_svc_type SERVICE_STATE
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic go = LONG_CALL.go;
	logic ea_q;
	always_ff @(posedge MCLK)
	begin
		if (RST)
			ea_q <= 1'b0;
		else if (SFR_REQ.wr && SFR_REQ.addr == 8'hA8)
			ea_q <= SFR_REQ.wdata[7];
	end
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	////////////////////////////////////////////////////////////////////////
	a_go_pulse: assert property (go |=> !go)
		else $error("call pulse too long");
	a_go_at_end: assert property (go |-> $past(INSTR_END && !RETURN_FROM_INTERRUPT_END))
		else $error("call off boundary");
	a_vector_map: assert property (go |-> LONG_CALL.vector[2:0] == 3'h3
		&& LONG_CALL.vector <= 16'h0073) else $error("bad vector");
	a_global_gate: assert property (go |-> $past(ea_q) || $past(ea_q, 2))
		else $error("call while masked");
	a_high_locks: assert property (go |-> SERVICE_STATE inside
		{tlic_pkg::SVC_IDLE, tlic_pkg::SVC_LOW}) else $error("preempted high");
	a_low_only_high: assert property (go && SERVICE_STATE ==
		tlic_pkg::SVC_LOW |-> LONG_CALL.high) else $error("low preempted");
	a_enter_low: assert property (go && !LONG_CALL.high && SERVICE_STATE ==
		tlic_pkg::SVC_IDLE |=> SERVICE_STATE == tlic_pkg::SVC_LOW)
		else $error("no low state");
	a_auto_clear: assert property (go && LONG_CALL.vector < 16'h0023 &&
		!$past(|(FLAG_HW_SET[3:0] | FLAG_SW_SET[3:0]))
		|-> !PENDING_FLAGS[LONG_CALL.vector[4:3]]) else $error("not cleared");
	a_prio_bit7: assert property (!$past(RST) && $past(SFR_REQ.addr) ==
		8'hB8 |-> SFR_RDATA[7]) else $error("priority bit 7 low");
	// Issue only acts on a request decoded one cycle earlier
	a_req_before_go: assert property (go |-> $past(IRQ_PENDING))
		else $error("call without request");
	c_high_call: cover property (go && LONG_CALL.high);
	c_nested: cover property (SERVICE_STATE == tlic_pkg::SVC_HIGH_OVER_LOW);
	c_last_vec: cover property (go && LONG_CALL.vector == 16'h0073);
endmodule
bind tlic_top tlic_checker #(.NUM_FLAG(NUM_FLAG)) i_chk (.MCLK(MCLK),
	.RST(RST), .SFR_REQ(SFR_REQ), .SFR_RDATA(SFR_RDATA),
	.FLAG_HW_SET(FLAG_HW_SET), .FLAG_SW_SET(FLAG_SW_SET),
	.PENDING_FLAGS(PENDING_FLAGS), .INSTR_END(INSTR_END),
	.RETURN_FROM_INTERRUPT_END(RETURN_FROM_INTERRUPT_END), .IRQ_PENDING(IRQ_PENDING), .LONG_CALL(LONG_CALL),
	.SERVICE_STATE(SERVICE_STATE));
`default_nettype wire

// File: bench/tlic_cpu_model.sv
// Instruction sequencer model facing the interrupt controller.
// Assumes the bench requests a return as a one-cycle pulse.
`default_nettype none
module tlic_cpu_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] gap,
	input wire logic return_from_interrupt_req,
	output logic instr_end,
	output logic return_from_interrupt_end
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cnt_q;
	logic ret_q;
	always_ff @(posedge clk)
	begin
		if (rst || cnt_q >= gap)
			cnt_q <= 3'h0;
		else
			cnt_q <= cnt_q + 3'h1;
	end
	// Return stays queued until an instruction boundary carries it
	always_ff @(posedge clk)
	begin
		if (rst)
			ret_q <= 1'b0;
		else if (return_from_interrupt_req)
			ret_q <= 1'b1;
		else if (instr_end)
			ret_q <= 1'b0;
	end
	assign instr_end = !rst && cnt_q >= gap;
	assign return_from_interrupt_end = instr_end && ret_q;
endmodule
`default_nettype wire

// File: hdl/tlic_pkg.sv
// Constants and types for the two-level interrupt controller.
// Assumes an 8-bit special-function register bus driven by the CPU core.
// Overview of operation
// - Events set pending flags regardless of any enable bit.
// - Enabled pending source raises request; long call at instruction end.
// - Return-from-interrupt resumes where the program was interrupted.
// - Source with individual enable clear never raises a request.
// - Global enable bit 7 must be one for any individual enable to count.
// - Flags set while globally disabled stay pending and are served later.
// - External 0/1 and timer 0/1 flags clear on vectoring; others by software.
// - Flag still set after return causes new request after one instruction.
// - Fifteen sources; software setting a flag acts like a hardware event.
// - Several flags may share one source and vector; any raises it.
// - Vectors: reset 0x0000, order n at 0x0003 plus eight times n.
// - Enable bits: base register 0-6, extended register 0-7 by order.
// - One priority bit per source at its enable position; one is high.
// - After reset all sources are low priority.
// - High may preempt low routine; nothing preempts a high routine.
// - Higher level first, then lowest fixed order number.
// - Requests decoded every cycle; fastest response 1 detect plus 4 call.
// - After return, one instruction runs before the pending call, or two if the first takes a single cycle.
// - Worst case 18 cycles: detect, return, divide, call.
// - Equal or lower requests wait for routine end plus one instruction.
// - Priority register bit 7 reads one, ignores writes; resets 0x80.
// - Enable register resets to zero; everything starts disabled.

`default_nettype none

package tlic_pkg;

	localparam int NUM_SRC = 15;
	localparam int NUM_FLAG = 23;

	// Register addresses in direct space
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hA8;
	localparam logic [7:0] ADDR_IRQ_PRIORITY = 8'hB8;
	localparam logic [7:0] ADDR_EXT_IRQ_ENABLE = 8'hE6;
	localparam logic [7:0] ADDR_EXT_IRQ_PRIORITY = 8'hF6;

	localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
	localparam logic [7:0] RST_IRQ_PRIORITY = 8'h80;
	localparam logic [7:0] RST_EXT_IRQ_ENABLE = 8'h00;
	localparam logic [7:0] RST_EXT_IRQ_PRIORITY = 8'h00;
	localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
	localparam int PRIO_UNUSED_BIT = 7;

	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	localparam logic [15:0] VECTOR_BASE = 16'h0003;
	localparam logic [15:0] VECTOR_STEP = 16'h0008;

	// Cycles the core spends on the long call; issue is blocked meanwhile
	localparam logic [2:0] LONG_CALL_CYCLES = 3'h4;

	// Pending flag positions
	localparam int F_EXT0 = 0;
	localparam int F_TMR0 = 1;
	localparam int F_EXT1 = 2;
	localparam int F_TMR1 = 3;
	localparam int F_UART_RX = 4;
	localparam int F_UART_TX = 5;
	localparam int F_TMR2_HI = 6;
	localparam int F_TMR2_LO = 7;
	localparam int F_SPI_DONE = 8;
	localparam int F_SPI_RXOVR = 11;
	localparam int F_ADC_WIN = 12;
	localparam int F_ADC_CONV = 13;
	localparam int F_PCA_OVF = 14;
	localparam int F_PCA_CAP2 = 17;
	localparam int F_CMP_FALL = 18;
	localparam int F_CMP_RISE = 19;
	localparam int F_LIN = 20;
	localparam int F_REG_DROP = 21;
	localparam int F_PORT_MATCH = 22;

	// Sources below this order have their flag auto-cleared on vectoring
	localparam int AUTO_CLEAR_SRCS = 4;

	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tlic_sfr_req_type;

	typedef struct packed {
		logic go;
		logic high;
		logic [15:0] vector;
	} tlic_call_type;

	typedef enum logic [1:0] {
		SVC_IDLE,
		SVC_LOW,
		SVC_HIGH,
		SVC_HIGH_OVER_LOW
	} tlic_svc_type;

endpackage

`default_nettype wire

// File: hdl/tlic_top.sv
// Two-level interrupt controller between peripheral flags and the CPU.
// Assumes the core pulses INSTR_END as each instruction completes,
// with RETURN_FROM_INTERRUPT_END alongside when that instruction was a return.

`default_nettype none

module tlic_top #(
	parameter int NUM_SRC = tlic_pkg::NUM_SRC,
	parameter int NUM_FLAG = tlic_pkg::NUM_FLAG
) (
	input wire logic MCLK,
	input wire logic RST,
	input wire tlic_pkg::tlic_sfr_req_type SFR_REQ,
	output logic [7:0] SFR_RDATA,
	input wire logic [NUM_FLAG-1:0] FLAG_HW_SET,
	input wire logic [NUM_FLAG-1:0] FLAG_SW_SET,
	input wire logic [NUM_FLAG-1:0] FLAG_SW_CLR,
	output logic [NUM_FLAG-1:0] PENDING_FLAGS,
	input wire logic INSTR_END,
	input wire logic RETURN_FROM_INTERRUPT_END,
	output logic IRQ_PENDING,
	output tlic_pkg::tlic_call_type LONG_CALL,
	output tlic_pkg::tlic_svc_type SERVICE_STATE
);

	////////////////////////////////////////////////////////////////////////
	// Elaboration checks

	if (NUM_SRC != tlic_pkg::NUM_SRC)
	begin : g_bad_src
		$error("Source count is fixed by the enable register layout");
	end
	if (NUM_FLAG != tlic_pkg::NUM_FLAG)
	begin : g_bad_flag
		$error("Flag count is fixed by the source grouping");
	end

	////////////////////////////////////////////////////////////////////////
	// Functions

	// Several flags funnel into one source
	function automatic logic [14:0] group_flags(input logic [22:0] f);
		logic [14:0] s;
		s = '0;
		s[0] = f[tlic_pkg::F_EXT0];
		s[1] = f[tlic_pkg::F_TMR0];
		s[2] = f[tlic_pkg::F_EXT1];
		s[3] = f[tlic_pkg::F_TMR1];
		s[4] = f[tlic_pkg::F_UART_RX] | f[tlic_pkg::F_UART_TX];
		s[5] = f[tlic_pkg::F_TMR2_HI] | f[tlic_pkg::F_TMR2_LO];
		s[6] = |f[tlic_pkg::F_SPI_RXOVR:tlic_pkg::F_SPI_DONE];
		s[7] = f[tlic_pkg::F_ADC_WIN];
		s[8] = f[tlic_pkg::F_ADC_CONV];
		s[9] = |f[tlic_pkg::F_PCA_CAP2:tlic_pkg::F_PCA_OVF];
		s[10] = f[tlic_pkg::F_CMP_FALL];
		s[11] = f[tlic_pkg::F_CMP_RISE];
		s[12] = f[tlic_pkg::F_LIN];
		s[13] = f[tlic_pkg::F_REG_DROP];
		s[14] = f[tlic_pkg::F_PORT_MATCH];
		return s;
	endfunction

	// Lowest order number wins within one level
	function automatic logic [3:0] first_set(input logic [14:0] v);
		logic [3:0] idx;
		idx = 4'hF;
		for (int i = 14; i >= 0; i--)
		begin
			if (v[i])
			begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction

	function automatic logic [15:0] vector_of(input logic [3:0] idx);
		logic [15:0] off;
		off = 16'(idx) * tlic_pkg::VECTOR_STEP;
		return tlic_pkg::VECTOR_BASE + off;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [7:0] irq_enable_q;
	logic [6:0] irq_priority_q;
	logic [7:0] ext_irq_enable_q;
	logic [7:0] ext_irq_priority_q;
	logic [22:0] flags_q;
	logic [22:0] flags_d;
	logic [7:0] rdata_d;
	logic [14:0] src_pending;
	logic [14:0] src_enable;
	logic [14:0] src_high;
	logic [14:0] armed;
	logic [14:0] req_high;
	logic [14:0] req_low;
	logic req_d;
	logic win_high_d;
	logic [3:0] win_idx_d;
	logic req_q;
	logic win_high_q;
	logic [3:0] win_idx_q;
	logic [2:0] call_cnt_q;
	logic issue;
	tlic_pkg::tlic_svc_type svc_q;

	////////////////////////////////////////////////////////////////////////
	// Register file

	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			irq_enable_q <= tlic_pkg::RST_IRQ_ENABLE;
			ext_irq_enable_q <= tlic_pkg::RST_EXT_IRQ_ENABLE;
		end
		else if (SFR_REQ.wr)
		begin
			if (SFR_REQ.addr == tlic_pkg::ADDR_IRQ_ENABLE)
			begin
				irq_enable_q <= SFR_REQ.wdata;
			end
			if (SFR_REQ.addr == tlic_pkg::ADDR_EXT_IRQ_ENABLE)
			begin
				ext_irq_enable_q <= SFR_REQ.wdata;
			end
		end
	end

	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			irq_priority_q <= tlic_pkg::RST_IRQ_PRIORITY[6:0];
			ext_irq_priority_q <= tlic_pkg::RST_EXT_IRQ_PRIORITY;
		end
		else if (SFR_REQ.wr)
		begin
			// Unused top bit has no storage, so writes to it vanish
			if (SFR_REQ.addr == tlic_pkg::ADDR_IRQ_PRIORITY)
			begin
				irq_priority_q <= SFR_REQ.wdata[6:0];
			end
			if (SFR_REQ.addr == tlic_pkg::ADDR_EXT_IRQ_PRIORITY)
			begin
				ext_irq_priority_q <= SFR_REQ.wdata;
			end
		end
	end

	always_comb
	begin
		unique case (SFR_REQ.addr)
			tlic_pkg::ADDR_IRQ_ENABLE: rdata_d = irq_enable_q;
			tlic_pkg::ADDR_IRQ_PRIORITY: rdata_d = {1'b1, irq_priority_q};
			tlic_pkg::ADDR_EXT_IRQ_ENABLE: rdata_d = ext_irq_enable_q;
			tlic_pkg::ADDR_EXT_IRQ_PRIORITY: rdata_d = ext_irq_priority_q;
			default: rdata_d = 8'h00;
		endcase
	end

	// Read data lags the address by one cycle
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			SFR_RDATA <= 8'h00;
		end
		else
		begin
			SFR_RDATA <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pending flags

	always_comb
	begin
		flags_d = flags_q & ~FLAG_SW_CLR;
		// Hardware auto-clear only for the first four sources
		if (issue && (win_idx_q < 4'(tlic_pkg::AUTO_CLEAR_SRCS)))
		begin
			flags_d[win_idx_q] = 1'b0;
		end
		// Sets applied last so a coincident event is never lost
		flags_d = flags_d | FLAG_HW_SET;
		flags_d = flags_d | FLAG_SW_SET;
	end

	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			flags_q <= '0;
		end
		else
		begin
			flags_q <= flags_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Masking and arbitration

	always_comb
	begin
		src_pending = group_flags(flags_q);
		src_enable = {ext_irq_enable_q, irq_enable_q[6:0]};
		src_high = {ext_irq_priority_q, irq_priority_q};
		armed = '0;
		if (irq_enable_q[tlic_pkg::GLOBAL_IRQ_ENABLE_BIT])
		begin
			armed = src_pending & src_enable;
		end
		req_high = armed & src_high;
		req_low = armed & ~src_high;
		req_d = 1'b0;
		win_high_d = 1'b0;
		win_idx_d = 4'hF;
		unique case (svc_q)
			// Nothing preempts a high routine
			tlic_pkg::SVC_HIGH, tlic_pkg::SVC_HIGH_OVER_LOW: req_d = 1'b0;
			tlic_pkg::SVC_LOW:
			begin
				req_d = |req_high;
				win_high_d = 1'b1;
				win_idx_d = first_set(req_high);
			end
			tlic_pkg::SVC_IDLE:
			begin
				req_d = |armed;
				win_high_d = |req_high;
				win_idx_d = (|req_high) ? first_set(req_high) : first_set(req_low);
			end
		endcase
	end

	// One cycle of detect, decoded afresh every clock
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			req_q <= 1'b0;
			win_high_q <= 1'b0;
			win_idx_q <= 4'hF;
		end
		else
		begin
			req_q <= req_d;
			win_high_q <= win_high_d;
			win_idx_q <= win_idx_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Call issue and service nesting

	// A return boundary never issues, so one more instruction always runs
	assign issue = req_q && INSTR_END && !RETURN_FROM_INTERRUPT_END && (call_cnt_q == 3'h0);

	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			call_cnt_q <= 3'h0;
		end
		else if (issue)
		begin
			call_cnt_q <= tlic_pkg::LONG_CALL_CYCLES;
		end
		else if (call_cnt_q != 3'h0)
		begin
			call_cnt_q <= call_cnt_q - 3'h1;
		end
	end

	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			LONG_CALL.go <= 1'b0;
			LONG_CALL.high <= 1'b0;
			// Reset overrides everything and always targets its own vector
			LONG_CALL.vector <= tlic_pkg::RESET_VECTOR;
		end
		else
		begin
			LONG_CALL.go <= issue;
			if (issue)
			begin
				LONG_CALL.high <= win_high_q;
				LONG_CALL.vector <= vector_of(win_idx_q);
			end
		end
	end

	// The core returns to its own saved address; only the level unwinds
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			svc_q <= tlic_pkg::SVC_IDLE;
		end
		else if (issue)
		begin
			unique case (svc_q)
				tlic_pkg::SVC_IDLE:
					svc_q <= win_high_q ? tlic_pkg::SVC_HIGH : tlic_pkg::SVC_LOW;
				tlic_pkg::SVC_LOW: svc_q <= tlic_pkg::SVC_HIGH_OVER_LOW;
				tlic_pkg::SVC_HIGH, tlic_pkg::SVC_HIGH_OVER_LOW: svc_q <= svc_q;
			endcase
		end
		else if (INSTR_END && RETURN_FROM_INTERRUPT_END)
		begin
			unique case (svc_q)
				tlic_pkg::SVC_HIGH_OVER_LOW: svc_q <= tlic_pkg::SVC_LOW;
				tlic_pkg::SVC_HIGH, tlic_pkg::SVC_LOW: svc_q <= tlic_pkg::SVC_IDLE;
				tlic_pkg::SVC_IDLE: svc_q <= tlic_pkg::SVC_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status outputs

	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			PENDING_FLAGS <= '0;
			IRQ_PENDING <= 1'b0;
			SERVICE_STATE <= tlic_pkg::SVC_IDLE;
		end
		else
		begin
			PENDING_FLAGS <= flags_d;
			IRQ_PENDING <= req_d;
			SERVICE_STATE <= svc_q;
		end
	end

endmodule

`default_nettype wire
